// [inc/psta_regs.vh]
`ifndef PSTA_REGS_VH
`define PSTA_REGS_VH
`define PSTA_PAGE_RESET 8'h00
`define PSTA_PAGE_CFG_BIT 7
`define PSTA_ADDR_STEP 16'h0002
`define PSTA_OP_RD_LOW 2'h0
`define PSTA_OP_RD_HIGH 2'h1
`define PSTA_OP_WT_LOW 2'h2
`define PSTA_OP_WT_HIGH 2'h3
`define PSTA_LAT_CYC 1
`endif

// [rtl/psta_read_format.v]
`timescale 1ns/100ps
module psta_read_format (
    input wire high_sel,
    input wire byte_mode,
    input wire byte_sel,
    input wire [23:0] prog_word,
    output reg [15:0] data_out
);
    always @* begin
        if (!high_sel) begin
            if (!byte_mode) begin
                data_out = prog_word[15:0];
            end else if (byte_sel) begin
                data_out = {8'h00, prog_word[15:8]};
            end else begin
                data_out = {8'h00, prog_word[7:0]};
            end
        end else begin
            if (byte_mode && byte_sel) begin
                data_out = 16'h0000;
            end else begin
                data_out = {8'h00, prog_word[23:16]};
            end
        end
    end
endmodule // psta_read_format

// [rtl/psta_table_access.v]
`timescale 1ns/100ps
`include "psta_regs.vh"
module psta_table_access #(
    parameter PAGE_W = 8
) (
    input wire sys_clk,
    input wire rst,
    // page register write from the core
    input wire page_wr,
    input wire [PAGE_W-1:0] page_wdata,
    output wire [PAGE_W-1:0] program_page_select,
    // table instruction request
    input wire req_valid,
    output wire req_ready,
    input wire [1:0] req_op,
    input wire req_byte_mode,
    input wire [15:0] req_ea,
    input wire [15:0] req_wdata,
    output reg rd_valid,
    output reg [15:0] rd_data,
    // program array side
    output reg mem_req,
    output reg mem_we,
    output reg [PAGE_W+15:0] mem_addr,
    output reg [2:0] mem_byte_en,
    output reg [23:0] mem_wdata,
    output reg mem_cfg_space,
    input wire mem_ack,
    input wire [23:0] mem_rdata
);
    localparam ST_IDLE = 2'b01;
    localparam ST_WAIT = 2'b10;
    localparam ADDR_W = PAGE_W + 16;

    // sequencing state
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [PAGE_W-1:0] page_r;
    reg [PAGE_W-1:0] page_nxt;

    // request kept for the answer cycle
    reg high_r;
    reg high_nxt;
    reg byte_mode_r;
    reg byte_mode_nxt;
    reg byte_sel_r;
    reg byte_sel_nxt;

    // array side next values
    reg mem_req_nxt;
    reg mem_we_nxt;
    reg [ADDR_W-1:0] mem_addr_nxt;
    reg [2:0] mem_byte_en_nxt;
    reg [23:0] mem_wdata_nxt;
    reg mem_cfg_space_nxt;

    // read return next values
    reg rd_valid_nxt;
    reg [15:0] rd_data_nxt;

    wire [15:0] fmt_data;
    wire is_write;
    wire is_high;
    wire take;
    wire cfg_sel;

    // op decode: write forms carry data toward the array
    function op_writes;
        input [1:0] op;
        begin
            case (op)
                `PSTA_OP_WT_LOW: begin
                    op_writes = 1'b1;
                end
                `PSTA_OP_WT_HIGH: begin
                    op_writes = 1'b1;
                end
                default: begin
                    op_writes = 1'b0;
                end
            endcase
        end
    endfunction

    // op decode: high forms reach only the upper byte space
    function op_high;
        input [1:0] op;
        begin
            case (op)
                `PSTA_OP_RD_HIGH: begin
                    op_high = 1'b1;
                end
                `PSTA_OP_WT_HIGH: begin
                    op_high = 1'b1;
                end
                default: begin
                    op_high = 1'b0;
                end
            endcase
        end
    endfunction

    // word address: ea bit 0 only selects a byte, words step by two
    function [ADDR_W-1:0] full_addr;
        input [PAGE_W-1:0] page;
        input [15:0] ea;
        begin
            full_addr = {page, ea[15:1], 1'b0};
        end
    endfunction

    // byte select one in byte mode names the phantom byte of the upper word
    function phantom_sel;
        input byte_mode;
        input byte_sel;
        begin
            phantom_sel = byte_mode & byte_sel;
        end
    endfunction

    // lanes: bit 0 program bits 7..0, bit 1 bits 15..8, bit 2 bits 23..16
    function [2:0] lane_enable;
        input high;
        input byte_mode;
        input byte_sel;
        begin
            if (high) begin
                if (phantom_sel(byte_mode, byte_sel)) begin
                    lane_enable = 3'h0;
                end else begin
                    lane_enable = 3'h4;
                end
            end else if (byte_mode) begin
                if (byte_sel) begin
                    lane_enable = 3'h2;
                end else begin
                    lane_enable = 3'h1;
                end
            end else begin
                lane_enable = 3'h3;
            end
        end
    endfunction

    // byte forms put the byte on every lane it may land in; the lane enable picks
    function [23:0] write_word;
        input high;
        input byte_mode;
        input [15:0] wdata;
        begin
            if (high) begin
                write_word = {wdata[7:0], 16'h0000};
            end else if (byte_mode) begin
                write_word = {8'h00, wdata[7:0], wdata[7:0]};
            end else begin
                write_word = {8'h00, wdata};
            end
        end
    endfunction

    assign program_page_select = page_r;
    assign req_ready = state_r[0];
    assign is_write = op_writes(req_op);
    assign is_high = op_high(req_op);
    assign take = req_valid & state_r[0];
    assign cfg_sel = page_r[`PSTA_PAGE_CFG_BIT];

    // page register: a write lands at the edge, later requests see it
    // a request taken on the same edge still uses the old page
    always @* begin
        page_nxt = page_r;
        if (page_wr) begin
            page_nxt = page_wdata;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            page_r <= `PSTA_PAGE_RESET;
        end else begin
            page_r <= page_nxt;
        end
    end

    psta_read_format u_fmt (
        .high_sel(high_r),
        .byte_mode(byte_mode_r),
        .byte_sel(byte_sel_r),
        .prog_word(mem_rdata),
        .data_out(fmt_data)
    );

    // sequencing: one request outstanding, ready again the cycle after the answer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (mem_ack) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // read formatting settings kept for the answer cycle
    always @* begin
        high_nxt = high_r;
        byte_mode_nxt = byte_mode_r;
        byte_sel_nxt = byte_sel_r;
        if (take) begin
            high_nxt = is_high;
            byte_mode_nxt = req_byte_mode;
            byte_sel_nxt = req_ea[0];
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            high_r <= 1'b0;
            byte_mode_r <= 1'b0;
            byte_sel_r <= 1'b0;
        end else begin
            high_r <= high_nxt;
            byte_mode_r <= byte_mode_nxt;
            byte_sel_r <= byte_sel_nxt;
        end
    end

    // array side holds every field until the edge after the answer
    always @* begin
        mem_req_nxt = mem_req;
        mem_we_nxt = mem_we;
        mem_addr_nxt = mem_addr;
        mem_byte_en_nxt = mem_byte_en;
        mem_wdata_nxt = mem_wdata;
        mem_cfg_space_nxt = mem_cfg_space;
        if (take) begin
            mem_req_nxt = 1'b1;
            mem_we_nxt = is_write;
            mem_addr_nxt = full_addr(page_r, req_ea);
            mem_cfg_space_nxt = cfg_sel;
            mem_byte_en_nxt = lane_enable(is_high, req_byte_mode, req_ea[0]);
            mem_wdata_nxt = write_word(is_high, req_byte_mode, req_wdata);
        end else if (state_r[1] && mem_ack) begin
            mem_req_nxt = 1'b0;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= {ADDR_W{1'b0}};
            mem_byte_en <= 3'h0;
            mem_wdata <= 24'h00_0000;
            mem_cfg_space <= 1'b0;
        end else begin
            mem_req <= mem_req_nxt;
            mem_we <= mem_we_nxt;
            mem_addr <= mem_addr_nxt;
            mem_byte_en <= mem_byte_en_nxt;
            mem_wdata <= mem_wdata_nxt;
            mem_cfg_space <= mem_cfg_space_nxt;
        end
    end

    // read result: one-cycle strobe, data stands until the next read
    always @* begin
        rd_valid_nxt = 1'b0;
        rd_data_nxt = rd_data;
        if (state_r[1] && mem_ack && !mem_we) begin
            rd_valid_nxt = 1'b1;
            rd_data_nxt = fmt_data;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            rd_valid <= rd_valid_nxt;
            rd_data <= rd_data_nxt;
        end
    end
endmodule // psta_table_access

// [dv/psta_table_access_properties.sv]
`timescale 1ns/100ps
module psta_props #(parameter PAGE_W = 8) (input wire sys_clk, rst, req_valid, req_ready, rd_valid, mem_req,
    mem_we, mem_ack, mem_cfg_space, req_byte_mode, input wire [1:0] req_op, input wire [15:0] req_ea,
    input wire [PAGE_W-1:0] program_page_select, input wire [PAGE_W+15:0] mem_addr, input wire [2:0] mem_byte_en);
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
sequence s_tk; req_valid && req_ready; endsequence
property p_go; s_tk |=> mem_req && !req_ready; endproperty
a_go: assert property (p_go) else $error("no array request after take");
property p_ad; s_tk |=> mem_addr == {$past(program_page_select), $past(req_ea[15:1]), 1'b0}; endproperty
a_ad: assert property (p_ad) else $error("bad array address");
property p_cf; mem_req |-> mem_cfg_space == mem_addr[PAGE_W+15]; endproperty
a_cf: assert property (p_cf) else $error("bad space select");
property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
a_hold: assert property (p_hold) else $error("request dropped early");
property p_rv; mem_req && mem_ack && !mem_we |=> rd_valid ##1 !rd_valid; endproperty
a_rv: assert property (p_rv) else $error("read valid pulse wrong");
property p_we; s_tk |=> mem_we == $past(req_op[1]); endproperty
a_we: assert property (p_we) else $error("bad write flag");
property p_hi; (s_tk and req_op == 2'h3) |=> mem_byte_en[1:0] == 2'h0
    && mem_byte_en[2] != ($past(req_byte_mode) & $past(req_ea[0])); endproperty
a_hi: assert property (p_hi) else $error("bad high lanes");
property p_lo; (s_tk and req_op == 2'h2) |=> !mem_byte_en[2] && mem_byte_en[1:0] != 2'h0; endproperty
a_lo: assert property (p_lo) else $error("bad low lanes");
endmodule // psta_props
bind psta_table_access psta_props #(.PAGE_W(PAGE_W)) u_props (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .rd_valid(rd_valid), .mem_req(mem_req), .mem_we(mem_we), .mem_ack(mem_ack),
    .mem_cfg_space(mem_cfg_space), .req_byte_mode(req_byte_mode), .req_op(req_op), .req_ea(req_ea),
    .program_page_select(program_page_select), .mem_addr(mem_addr), .mem_byte_en(mem_byte_en));

// [dv/psta_mem_model.sv]
`timescale 1ns/100ps
module psta_mem_model (input wire sys_clk, slow, mem_req, mem_we, input wire [23:0] mem_addr, mem_wdata,
    input wire [2:0] mem_byte_en, output logic mem_ack = 0, output logic [23:0] mem_rdata = 24'h00_0000);
logic [23:0] mem [32];
logic [1:0] cnt = 2'h0;
wire [4:0] ix = {mem_addr[23], mem_addr[4:1]};
always @(posedge sys_clk) begin
    mem_ack <= 0;
    mem_rdata <= ~mem_rdata; // idle bus inverts every bit each cycle, so the last read word returns every other cycle
    if (mem_req && !mem_ack && cnt < {slow, 1'b0}) cnt <= cnt + 2'h1;
    else if (mem_req && !mem_ack) begin
        cnt <= 2'h0;
        mem_ack <= 1;
        for (int b = 0; b < 3; b++) if (mem_we && mem_byte_en[b]) mem[ix][8*b+:8] <= mem_wdata[8*b+:8];
        if (!mem_we) mem_rdata <= mem[ix];
    end
end
endmodule // psta_mem_model

// [dv/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
logic sys_clk = 0, rst = 1, page_wr = 0, req_valid = 0, req_byte_mode = 0, slow = 0;
logic [7:0] page_wdata = 8'h00;
logic [1:0] req_op = 2'h0;
logic [15:0] req_ea = 16'h0000, req_wdata = 16'h0000;
wire [7:0] program_page_select;
wire req_ready, rd_valid, mem_req, mem_we, mem_cfg_space, mem_ack;
wire [15:0] rd_data;
wire [23:0] mem_addr, mem_wdata, mem_rdata;
wire [2:0] mem_byte_en;
int mismatches = 0, compares = 0;
always #2 sys_clk = ~sys_clk;
psta_table_access dut (.sys_clk(sys_clk), .rst(rst), .page_wr(page_wr), .page_wdata(page_wdata),
    .program_page_select(program_page_select), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_byte_mode(req_byte_mode), .req_ea(req_ea), .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_byte_en(mem_byte_en), .mem_wdata(mem_wdata),
    .mem_cfg_space(mem_cfg_space), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
psta_mem_model mem (.sys_clk(sys_clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_byte_en(mem_byte_en), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
task automatic finish_test;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
task automatic cmp(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
        mismatches++;
        $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
endtask
task automatic op(input logic [1:0] o, input logic bm, input logic [15:0] ea, wd, ex);
    int n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
        @(posedge sys_clk);
        #1;
        n++;
    end
    req_valid <= 1; req_op <= o; req_byte_mode <= bm; req_ea <= ea; req_wdata <= wd;
    @(posedge sys_clk);
    req_valid <= 0;
    do begin @(posedge sys_clk); #1; end while (req_ready !== 1'b1 && ++n < 50);
    if (n >= 50) begin
        mismatches++;
        finish_test;
    end else if (!o[1]) begin
        cmp(rd_valid, 1'b1);
        cmp(rd_data, ex);
    end
endtask
task automatic pg(input logic [7:0] v);
    page_wr <= 1; page_wdata <= v;
    @(posedge sys_clk); #1;
    page_wr <= 0;
    cmp(program_page_select, v);
endtask
initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk); #1;
    cmp(program_page_select, 8'h00);
    pg(8'h01);
    op(2'h2, 0, 16'h0010, 16'hA5C3, 16'h0);
    op(2'h3, 0, 16'h0010, 16'h005A, 16'h0);
    op(2'h0, 0, 16'h0010, 16'h0, 16'hA5C3);
    op(2'h0, 1, 16'h0011, 16'h0, 16'h00A5);
    op(2'h0, 1, 16'h0010, 16'h0, 16'h00C3);
    op(2'h1, 0, 16'h0010, 16'h0, 16'h005A);
    op(2'h1, 1, 16'h0010, 16'h0, 16'h005A);
    op(2'h1, 1, 16'h0011, 16'h0, 16'h0000);
    slow <= 1;
    op(2'h3, 1, 16'h0011, 16'h00FF, 16'h0);
    op(2'h2, 1, 16'h0011, 16'h0077, 16'h0);
    op(2'h0, 0, 16'h0010, 16'h0, 16'h77C3);
    op(2'h1, 0, 16'h0010, 16'h0, 16'h005A);
    pg(8'h81);
    op(2'h2, 0, 16'h0010, 16'h1234, 16'h0);
    op(2'h0, 0, 16'h0010, 16'h0, 16'h1234);
    pg(8'h01);
    op(2'h0, 0, 16'h0010, 16'h0, 16'h77C3);
    op(2'h2, 0, 16'h0012, 16'hBEEF, 16'h0);
    op(2'h0, 0, 16'h0010, 16'h0, 16'h77C3);
    finish_test;
end
endmodule // tb_top
